/* File: src/vid_input_gpio_change_detect.v */
// code input port with change detect, general outputs and avalon register slave
//
// Behaviour
// - threshold_select 0 picks about 1 V switching, 1 picks 0.6 V.
// - bit 7 of code/io register selects shared pin: supply input or sixth code.
// - with pin select 0, bit 5 of code/io register reads zero.
// - with pin select 1, bit 5 returns the shared pin level outside gpio mode and the stored output level in gpio mode.
// - with pin select 0, status bit 0 reports supply out-of-limit results.
// - with pin select 1, status bit 0 reports code changes while config five bit 4 is clear.
// - flag sets when code differs from its value 11 us earlier.
// - code change raises alert unless mask register two bit 0 is set.
// - config five bit 4 turns code inputs into general outputs.
// - general outputs 0 to 5 drive the level last written in the code bits; general io 6 drives low.
// - independent general io 6 mode set by config five bits 3 to 2.
// - general io lines 0 to 4 on the code pins, 5 on the shared pin with pin select 1, and 6 independent.
// - bits 0 to 4 of code/io return the five code input levels outside gpio mode and the stored output levels in gpio mode.
`timescale 1ns/10ps
`include "code_port_defines.vh"
module vid_input_gpio_change_detect #(
  parameter WINDOW_CYCLES = `WINDOW_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg [1:0] response,
  // code pins, two-way as general outputs
  input wire [4:0] code_pin_in,
  output reg [4:0] code_pin_out,
  output reg [4:0] code_pin_oe,
  // shared pin used as sixth code input
  input wire shared_pin_in,
  output reg shared_pin_oe,
  output reg shared_pin_out,
  // independent general io
  input wire independent_general_io_in,
  output reg independent_general_io_out,
  output reg independent_general_io_oe,
  // analog front end
  output reg threshold_select,
  output reg supply_measure_en,
  input wire supply_limit_event,
  // alert
  output reg irq
);
  reg [7:0] code_io_q;
  reg [7:0] mask_q;
  reg [7:0] config_q;
  reg [7:0] status_q;
  reg [5:0] code_ref_q;
  reg [15:0] win_cnt_q;
  wire [5:0] code_sync;
  wire io6_sync;
  wire pin_func;
  wire gpio_en;
  wire [5:0] code_now;
  wire window_end;
  reg code_changed;
  reg flag_event;
  wire access;
  wire wr_done;
  reg [7:0] read_val;
  reg mapped;
  reg [7:0] code_rb;
  reg [1:0] bus_state_q;
  reg [1:0] bus_state_d;
  // one-hot bus states
  localparam BUS_IDLE = 2'b01;
  localparam BUS_ANSWER = 2'b10;

  level_sync #(.WIDTH(7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({independent_general_io_in, shared_pin_in, code_pin_in}),
    .sync_out({io6_sync, code_sync})
  );

  assign pin_func = code_io_q[`BIT_PIN_FUNC];
  assign gpio_en = config_q[`BIT_GPIO_EN];
  // sixth bit reads zero while the shared pin measures the supply
  assign code_now = {code_sync[5] & pin_func, code_sync[4:0]};

  // the window ends when the counter has run down
  assign window_end = (win_cnt_q == 16'h0000);

  // compare the code against the sample taken one window earlier
  always @* begin
    code_changed = 1'b0;
    if (window_end && (code_now != code_ref_q)) begin
      code_changed = 1'b1;
    end
  end

  // shared status bit: supply event or code change, by pin function
  always @* begin
    flag_event = 1'b0;
    if (pin_func) begin
      // outputs in gpio mode are not watched for changes
      flag_event = code_changed & ~gpio_en;
    end else begin
      flag_event = supply_limit_event;
    end
  end

  // a request is taken only while the slave is idle
  assign access = (read | write) & bus_state_q[0];
  // a write lands at the edge where waitrequest is seen low
  assign wr_done = write & bus_state_q[1] & byteenable[0];

  // code/io readback
  always @* begin
    code_rb = 8'h00;
    if (gpio_en) begin
      // stored output levels; bit 5 only exists as a code line
      code_rb = {code_io_q[7:6], code_io_q[5] & pin_func, code_io_q[4:0]};
    end else begin
      code_rb = {code_io_q[7:6], code_now};
    end
  end

  // register decode
  always @* begin
    read_val = 8'h00;
    mapped = 1'b0;
    if (address == `ADDR_INT_STATUS_TWO) begin
      read_val = status_q;
      mapped = 1'b1;
    end else if (address == `ADDR_CODE_IO) begin
      read_val = code_rb;
      mapped = 1'b1;
    end else if (address == `ADDR_INT_MASK_TWO) begin
      read_val = mask_q;
      mapped = 1'b1;
    end else if (address == `ADDR_CONFIG_FIVE) begin
      read_val = config_q;
      mapped = 1'b1;
    end
  end

  // window counter reloads each time it runs down
  always @(posedge clk) begin
    if (!rst_n) begin
      win_cnt_q <= 16'h0000;
    end else if (window_end) begin
      win_cnt_q <= WINDOW_CYCLES[15:0] - 16'h0001;
    end else begin
      win_cnt_q <= win_cnt_q - 16'h0001;
    end
  end

  // reference sample taken at each window end
  always @(posedge clk) begin
    if (!rst_n) begin
      code_ref_q <= 6'h00;
    end else if (window_end) begin
      code_ref_q <= code_now;
    end
  end

  // bus state: idle, then one answer cycle with waitrequest low
  always @* begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (access) begin
          bus_state_d = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_d = BUS_IDLE;
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  // waitrequest drops only in the answer cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      bus_state_q <= BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      bus_state_q <= bus_state_d;
      waitrequest <= ~bus_state_d[1];
    end
  end

  // read data and response captured at the take edge, standing in the answer cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
      response <= 2'h0;
    end else begin
      response <= 2'h0;
      if (access && read) begin
        readdata <= {24'h000000, read_val};
        if (!mapped) begin
          response <= 2'h2;
        end
      end
      if (access && write && !mapped) begin
        response <= 2'h2;
      end
    end
  end

  // code/io register; bit 5 keeps its level for the shared output
  always @(posedge clk) begin
    if (!rst_n) begin
      code_io_q <= `RESET_CODE_IO;
    end else if (wr_done && address == `ADDR_CODE_IO) begin
      code_io_q <= writedata[7:0];
    end
  end

  // interrupt mask two
  always @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `RESET_MASK;
    end else if (wr_done && address == `ADDR_INT_MASK_TWO) begin
      mask_q <= writedata[7:0];
    end
  end

  // configuration five
  always @(posedge clk) begin
    if (!rst_n) begin
      config_q <= `RESET_CONFIG;
    end else if (wr_done && address == `ADDR_CONFIG_FIVE) begin
      config_q <= writedata[7:0];
    end
  end

  // read clears, a new event in the same cycle wins
  always @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else if (access && read && address == `ADDR_INT_STATUS_TWO) begin
      status_q <= {7'h00, flag_event};
    end else begin
      status_q <= {7'h00, status_q[`BIT_FLAG] | flag_event};
    end
  end

  // code pins become general outputs in gpio mode
  always @(posedge clk) begin
    if (!rst_n) begin
      code_pin_out <= 5'h00;
      code_pin_oe <= 5'h00;
    end else begin
      code_pin_out <= code_io_q[4:0];
      code_pin_oe <= {5{gpio_en}};
    end
  end

  // shared pin is a general output only while it serves as a code line
  always @(posedge clk) begin
    if (!rst_n) begin
      shared_pin_out <= 1'b0;
      shared_pin_oe <= 1'b0;
    end else begin
      shared_pin_out <= code_io_q[`BIT_CODE_SIX];
      shared_pin_oe <= gpio_en & pin_func;
    end
  end

  // independent io: output level fixed low, direction from config five
  always @(posedge clk) begin
    if (!rst_n) begin
      independent_general_io_out <= 1'b0;
      independent_general_io_oe <= 1'b0;
    end else begin
      independent_general_io_out <= 1'b0;
      independent_general_io_oe <=
        (config_q[`BIT_IO6_MODE_HI:`BIT_IO6_MODE_LO] == `IO6_MODE_OUTPUT);
    end
  end

  // analog front end controls
  always @(posedge clk) begin
    if (!rst_n) begin
      threshold_select <= 1'b0;
      supply_measure_en <= 1'b1;
    end else begin
      threshold_select <= code_io_q[`BIT_THRESHOLD];
      supply_measure_en <= ~pin_func;
    end
  end

  // level alert while an unmasked status bit is set
  always @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= status_q[`BIT_FLAG] & ~mask_q[`BIT_FLAG];
    end
  end
endmodule

/* File: src/code_port_defines.vh */
// register offsets, field positions, reset values and timing counts of the code port
`ifndef CODE_PORT_DEFINES_VH
`define CODE_PORT_DEFINES_VH
`define ADDR_INT_STATUS_TWO 8'h42
`define ADDR_CODE_IO 8'h43
`define ADDR_INT_MASK_TWO 8'h75
`define ADDR_CONFIG_FIVE 8'h7c
`define BIT_FLAG 0
`define BIT_CODE_SIX 5
`define BIT_THRESHOLD 6
`define BIT_PIN_FUNC 7
`define BIT_GPIO_EN 4
`define BIT_IO6_MODE_LO 2
`define BIT_IO6_MODE_HI 3
`define IO6_MODE_OUTPUT 2'h1
`define RESET_CODE_IO 8'h00
`define RESET_MASK 8'h00
`define RESET_CONFIG 8'h00
`define CLK_HZ 40000000
`define WINDOW_NS 11000
`define WINDOW_CYCLES ((`WINDOW_NS * (`CLK_HZ / 1000000)) / 1000)
`endif

/* File: src/level_sync.v */
// two-stage synchroniser for a bus of levels
`timescale 1ns/10ps
module level_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: bench/code_port_properties.sv */
// assertions on the code port's pins and register bus
`timescale 1ns/10ps
module code_port_props (
  // clock, reset and bus
  input wire clk, rst_n, read, write, waitrequest,
  input wire [7:0] address,
  input wire [31:0] writedata, readdata,
  input wire [1:0] response,
  input wire [3:0] byteenable,
  // pins
  input wire [4:0] code_pin_oe,
  input wire shared_pin_oe, independent_general_io_oe, threshold_select, supply_measure_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr = write && !waitrequest && byteenable[0] && address == 8'h43;
  wire ans43 = read && !waitrequest && address == 8'h43;
  property p_thr; wr |-> ##2 threshold_select == $past(writedata[6], 2); endproperty
  a_thr: assert property (p_thr) else $error("threshold");
  property p_sel; wr |-> ##2 supply_measure_en == !$past(writedata[7], 2); endproperty
  a_sel: assert property (p_sel) else $error("pin select");
  property p_b5; ans43 && supply_measure_en |-> !readdata[5]; endproperty
  a_b5: assert property (p_b5) else $error("bit 5");
  property p_oe; code_pin_oe == 5'h00 || code_pin_oe == 5'h1f; endproperty
  a_oe: assert property (p_oe) else $error("code oe");
  property p_io6;
    !$stable(independent_general_io_oe) |-> $past(write, 2) && $past(address, 2) == 8'h7c;
  endproperty
  a_io6: assert property (p_io6) else $error("io6 oe");
  property p_sh; shared_pin_oe |-> !supply_measure_en; endproperty
  a_sh: assert property (p_sh) else $error("shared oe");
  property p_wl; !waitrequest |=> waitrequest; endproperty
  a_wl: assert property (p_wl) else $error("waitrequest");
  property p_un; read && !waitrequest && !(address inside {8'h42, 8'h43, 8'h75, 8'h7c})
    |-> response == 2'h2 && readdata == 32'h0; endproperty
  a_un: assert property (p_un) else $error("unmapped");
endmodule
bind vid_input_gpio_change_detect code_port_props props_u (.*);

/* File: bench/code_lines.sv */
// model of the regulator's code lines
`timescale 1ns/10ps
module code_lines (
  input wire [5:0] code,
  input wire [4:0] code_pin_oe, code_pin_out,
  input wire shared_pin_oe, shared_pin_out,
  output wire [4:0] code_pin_in,
  output wire shared_pin_in
);
  // regulator yields a line while the port drives it
  assign code_pin_in = (code_pin_oe & code_pin_out) | (~code_pin_oe & code[4:0]);
  assign shared_pin_in = shared_pin_oe ? shared_pin_out : code[5];
endmodule

/* File: bench/tb.sv */
// self-checking bench of the code port
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
  logic clk = 0, rst_n = 0, read = 0, write = 0, sev = 0;
  logic [7:0] address = 0, rd, v;
  logic [31:0] writedata = 0;
  logic [3:0] byteenable = 0;
  logic [5:0] code = 0;
  logic [1:0] rs;
  wire [31:0] readdata;
  wire [1:0] response;
  wire [4:0] cin, cout, coe;
  wire waitrequest, sh_oe, sh_out, sh_in, irq, io6_oe, thr, sme;
  int n_mismatch = 0, cmp_count = 0;
  localparam int W = 8;
  always #12.5 clk = ~clk;
  vid_input_gpio_change_detect #(.WINDOW_CYCLES(W)) dut_u (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .code_pin_in(cin), .code_pin_out(cout), .code_pin_oe(coe),
    .shared_pin_in(sh_in), .shared_pin_oe(sh_oe), .shared_pin_out(sh_out),
    .independent_general_io_in(1'b0), .independent_general_io_out(),
    .independent_general_io_oe(io6_oe), .threshold_select(thr), .supply_measure_en(sme),
    .supply_limit_event(sev), .irq(irq));
  code_lines line_u (.code(code), .code_pin_oe(coe), .code_pin_out(cout),
    .shared_pin_oe(sh_oe), .shared_pin_out(sh_out), .code_pin_in(cin), .shared_pin_in(sh_in));
  task finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    address <= a; read <= !w; write <= w; writedata <= {24'h0, d}; byteenable <= 4'hf;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    rs = response;
    read <= 0;
    write <= 0;
  endtask
  task rchk(input logic [7:0] a, e);
    bus(0, a, 8'h00);
    `CHK("read", e, rd)
  endtask
  task waitw;
    repeat (3 * W + 6) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h4678));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    code <= $urandom;
    repeat (4) @(posedge clk);
    rchk(8'h43, {3'h0, code[4:0]});
    bus(1, 8'h43, 8'hc0);
    repeat (2) @(posedge clk);
    `CHK("thr", 1'b1, thr)
    `CHK("sme", 1'b0, sme)
    repeat (4) @(posedge clk);
    rchk(8'h43, {2'h3, code});
    waitw;
    bus(0, 8'h42, 8'h00);
    waitw;
    rchk(8'h42, 8'h00);
    code <= code ^ 6'h20;
    waitw;
    `CHK("irq", 1'b1, irq)
    rchk(8'h42, 8'h01);
    rchk(8'h42, 8'h00);
    bus(1, 8'h75, 8'h01);
    code <= code ^ 6'h01;
    waitw;
    `CHK("irq", 1'b0, irq)
    rchk(8'h42, 8'h01);
    bus(1, 8'h43, 8'h00);
    sev <= 1;
    @(posedge clk);
    sev <= 0;
    repeat (2) @(posedge clk);
    rchk(8'h42, 8'h01);
    v = $urandom;
    bus(1, 8'h7c, 8'h14);
    bus(1, 8'h43, v);
    repeat (2) @(posedge clk);
    `CHK("oe", 5'h1f, coe)
    `CHK("out", v[4:0], cout)
    `CHK("io6", 1'b1, io6_oe)
    `CHK("sh_oe", v[7], sh_oe)
    `CHK("sh_out", v[5], sh_out)
    rchk(8'h43, {v[7:6], v[5] & v[7], v[4:0]});
    bus(1, 8'h7c, 8'h08);
    repeat (2) @(posedge clk);
    `CHK("io6", 1'b0, io6_oe)
    `CHK("oe", 5'h00, coe)
    rchk(8'h50, 8'h00);
    `CHK("resp", 2'h2, rs)
    finish_test;
  end
  initial begin
    #(25 * 5000);
    n_mismatch++;
    finish_test;
  end
endmodule
